//--- aw_flag_logic.sv
`timescale 1ns/1ps
// Function
// - All three status bytes read zero after reset until a comparison happens.
// - Primary alarm bit 7 set while temperature above upper alarm limit.
// - Primary alarm bit 6 set while temperature below lower alarm limit.
// - Primary alarm bit 5 set while supply above upper alarm limit.
// - Primary alarm bit 4 set while supply below lower alarm limit.
// - Primary alarm bit 3 set while laser bias above upper alarm limit.
// - Primary alarm bit 2 set while laser bias below lower alarm limit.
// - Primary alarm bit 1 set while transmit power above upper alarm limit.
// - Primary alarm bit 0 set while transmit power below lower alarm limit.
// - Receive alarm bit 7 set while receive power above overload limit.
// - Receive alarm bit 6 set while receive power below signal-loss limit.
// - Warning bit 7 set while temperature above upper warning limit.
// - Warning bit 6 set while temperature below lower warning limit.
// - Warning bit 5 set while supply above upper warning limit.
// - Warning bit 4 set while supply below lower warning limit.
// - Warning bit 3 set while laser bias above upper warning limit.
// - Warning bit 2 set while laser bias below lower warning limit.
// - Warning bit 1 set while transmit power above upper warning limit.
// - Warning bit 0 set while transmit power below lower warning limit.
module aw_flag_logic (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire aw_pkg::aw_meas_s meas,
    input wire aw_pkg::aw_limit_s [aw_pkg::AW_NUM_PRI-1:0] alarm_limit,
    input wire aw_pkg::aw_limit_s [aw_pkg::AW_NUM_PRI-1:0] warn_limit,
    input wire aw_pkg::aw_limit_s rx_alarm_limit,
    input wire aw_pkg::aw_req_s req,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic [7:0] alarm_status_primary,
    output logic [7:0] alarm_status_rx_power,
    output logic [7:0] warning_status_primary
);

    // ==========================================================
    // Comparators
    // ==========================================================
    // Temperature is two's complement; the other readings are unsigned
    function automatic logic is_above(
        input logic [aw_pkg::AW_READING_W-1:0] v,
        input logic [aw_pkg::AW_READING_W-1:0] lim,
        input logic signed_cmp
    );
        if (signed_cmp) begin
            return $signed(v) > $signed(lim);
        end
        return v > lim;
    endfunction

    function automatic logic is_below(
        input logic [aw_pkg::AW_READING_W-1:0] v,
        input logic [aw_pkg::AW_READING_W-1:0] lim,
        input logic signed_cmp
    );
        if (signed_cmp) begin
            return $signed(v) < $signed(lim);
        end
        return v < lim;
    endfunction

    // ==========================================================
    // Primary channels: heat, supply, bias, transmit power
    // ==========================================================
    logic [aw_pkg::AW_NUM_PRI-1:0] pri_alarm_hi_q;
    logic [aw_pkg::AW_NUM_PRI-1:0] pri_alarm_lo_q;
    logic [aw_pkg::AW_NUM_PRI-1:0] pri_warn_hi_q;
    logic [aw_pkg::AW_NUM_PRI-1:0] pri_warn_lo_q;

    genvar gi;
    generate
        for (gi = 0; gi < aw_pkg::AW_NUM_PRI; gi++) begin : g_pri
            localparam aw_pkg::aw_chan_e CH = aw_pkg::aw_chan_e'(3'(gi));
            localparam logic SGN = (CH == aw_pkg::AW_CH_HEAT);
            logic hit;

            assign hit = meas.valid && (meas.chan == CH);

            // Flags hold between conversions, so a read never sees a
            // half-updated comparison
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pri_alarm_hi_q[gi] <= 1'b0;
                    pri_alarm_lo_q[gi] <= 1'b0;
                end else if (hit) begin
                    pri_alarm_hi_q[gi] <= is_above(meas.value, alarm_limit[gi].upper, SGN);
                    pri_alarm_lo_q[gi] <= is_below(meas.value, alarm_limit[gi].lower, SGN);
                end
            end

            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pri_warn_hi_q[gi] <= 1'b0;
                    pri_warn_lo_q[gi] <= 1'b0;
                end else if (hit) begin
                    pri_warn_hi_q[gi] <= is_above(meas.value, warn_limit[gi].upper, SGN);
                    pri_warn_lo_q[gi] <= is_below(meas.value, warn_limit[gi].lower, SGN);
                end
            end

            assign alarm_status_primary[aw_pkg::AW_HIGH_BIT_TOP-2*gi] = pri_alarm_hi_q[gi];
            assign alarm_status_primary[aw_pkg::AW_LOW_BIT_TOP-2*gi] = pri_alarm_lo_q[gi];
            assign warning_status_primary[aw_pkg::AW_HIGH_BIT_TOP-2*gi] = pri_warn_hi_q[gi];
            assign warning_status_primary[aw_pkg::AW_LOW_BIT_TOP-2*gi] = pri_warn_lo_q[gi];
        end
    endgenerate

    // ==========================================================
    // Receive power channel
    // ==========================================================
    logic rx_over_q;
    logic rx_loss_q;
    logic rx_hit;

    assign rx_hit = meas.valid && (meas.chan == aw_pkg::AW_CH_RXPOWER);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_over_q <= 1'b0;
            rx_loss_q <= 1'b0;
        end else if (rx_hit) begin
            rx_over_q <= is_above(meas.value, rx_alarm_limit.upper, 1'b0);
            rx_loss_q <= is_below(meas.value, rx_alarm_limit.lower, 1'b0);
        end
    end

    assign alarm_status_rx_power[aw_pkg::AW_RX_OVER_BIT] = rx_over_q;
    assign alarm_status_rx_power[aw_pkg::AW_RX_LOSS_BIT] = rx_loss_q;
    // Reserved bits are constant; whatever the host writes has no path here
    assign alarm_status_rx_power[5:0] = aw_pkg::AW_RX_RSVD_VAL;

    // ==========================================================
    // Host read port
    // ==========================================================
    logic [7:0] rsp_data_q;
    logic rsp_valid_q;
    logic sel;

    assign sel = (req.dev == aw_pkg::AW_DEV_SEL);

    // Writes (req.wr) are decoded nowhere: all three bytes are status only
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_data_q <= aw_pkg::AW_FLAG_RESET;
        end else if (req.rd && sel) begin
            case (req.addr)
                aw_pkg::AW_ALARM_PRI_OFS: begin
                    rsp_data_q <= alarm_status_primary;
                end
                aw_pkg::AW_ALARM_RX_OFS: begin
                    rsp_data_q <= alarm_status_rx_power;
                end
                aw_pkg::AW_WARN_PRI_OFS: begin
                    rsp_data_q <= warning_status_primary;
                end
                default: begin
                    rsp_data_q <= aw_pkg::AW_UNMAPPED_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= req.rd && sel;
        end
    end

    assign rsp_data = rsp_data_q;
    assign rsp_valid = rsp_valid_q;

endmodule // aw_flag_logic

//--- aw_pkg.sv
package aw_pkg;

    // ==========================================================
    // Register map, at device select byte 8'ha2
    // ==========================================================
    localparam logic [7:0] AW_DEV_SEL = 8'ha2;
    localparam logic [7:0] AW_ALARM_PRI_OFS = 8'h70;
    localparam logic [7:0] AW_ALARM_RX_OFS = 8'h71;
    localparam logic [7:0] AW_WARN_PRI_OFS = 8'h74;
    localparam logic [7:0] AW_FLAG_RESET = 8'h00;
    localparam logic [7:0] AW_UNMAPPED_DATA = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    // Primary channel i uses bit 7-2i for high and 6-2i for low
    localparam int AW_NUM_PRI = 4;
    localparam int AW_HIGH_BIT_TOP = 7;
    localparam int AW_LOW_BIT_TOP = 6;
    localparam int AW_RX_OVER_BIT = 7;
    localparam int AW_RX_LOSS_BIT = 6;
    localparam logic [5:0] AW_RX_RSVD_VAL = 6'h00;

    localparam int AW_READING_W = 16;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        AW_CH_HEAT = 3'h0,
        AW_CH_SUPPLY = 3'h1,
        AW_CH_BIAS = 3'h2,
        AW_CH_TXPOWER = 3'h3,
        AW_CH_RXPOWER = 3'h4
    } aw_chan_e;

    typedef struct packed {
        logic valid;
        aw_chan_e chan;
        logic [AW_READING_W-1:0] value;
    } aw_meas_s;

    typedef struct packed {
        logic [AW_READING_W-1:0] upper;
        logic [AW_READING_W-1:0] lower;
    } aw_limit_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] dev;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aw_req_s;

endpackage

//--- aw_flag_monitor.sv
`timescale 1ns/1ps
module aw_flag_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire aw_pkg::aw_meas_s meas,
    input wire aw_pkg::aw_limit_s [3:0] alarm_limit,
    input wire aw_pkg::aw_limit_s [3:0] warn_limit,
    input wire aw_pkg::aw_limit_s rx_alarm_limit,
    input wire aw_pkg::aw_req_s req,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic [7:0] alarm_status_primary,
    input wire logic [7:0] alarm_status_rx_power,
    input wire logic [7:0] warning_status_primary
);
    wire [7:0] ap = alarm_status_primary;
    wire [7:0] ar = alarm_status_rx_power;
    wire [7:0] aw = warning_status_primary;
    wire [15:0] v = meas.value;
    // Valid bit on top, so 4'h8 means a heat conversion
    wire [3:0] c = {meas.valid, meas.chan};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    heat_hi_a: assert property (c == 4'h8 |=> ap[7] ==
        ($signed($past(v)) > $signed($past(alarm_limit[0].upper)))) else $error("heat hi");
    heat_warn_a: assert property (c == 4'h8 |=> aw[6] ==
        ($signed($past(v)) < $signed($past(warn_limit[0].lower)))) else $error("heat warn");
    supply_lo_a: assert property (c == 4'h9 |=>
        ap[4] == ($past(v) < $past(alarm_limit[1].lower))) else $error("supply lo");
    bias_hi_a: assert property (c == 4'ha |=>
        ap[3] == ($past(v) > $past(alarm_limit[2].upper))) else $error("bias hi");
    tx_warn_a: assert property (c == 4'hb |=>
        aw[1] == ($past(v) > $past(warn_limit[3].upper))) else $error("tx warn");
    rx_over_a: assert property (c == 4'hc |=> ar[5:0] == 6'h00 &&
        ar[7] == ($past(v) > $past(rx_alarm_limit.upper))) else $error("rx over");
    flags_hold_a: assert property (!meas.valid |=>
        $stable({ap, ar, aw})) else $error("flags moved");
    read_data_a: assert property (req.rd && req.dev == 8'ha2 && req.addr == 8'h74
        |=> rsp_valid && rsp_data == $past(aw)) else $error("read data");
endmodule // aw_flag_monitor
bind aw_flag_logic aw_flag_monitor mon (.*);

//--- aw_host.sv
`timescale 1ns/1ps
module aw_host (
    input wire logic core_clk,
    output aw_pkg::aw_req_s req,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid
);
    initial req = '0;
    task rd(input logic [7:0] dv, a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        req <= '{1'b1, 1'b0, dv, a, 8'h00};
        @(posedge core_clk);
        // Idle fields inverted so stale select bits cannot pass
        req <= '{1'b0, 1'b0, ~dv, ~a, 8'h00};
        repeat (2) begin
            @(posedge core_clk);
            if (rsp_valid === 1'b1 && !ok) begin
                ok = 1'b1;
                d = rsp_data;
            end
        end
    endtask
    task wr(input logic [7:0] a, d);
        req <= '{1'b0, 1'b1, 8'ha2, a, (a == 8'h71) ? {d[7:6], 6'h00} : d};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask
endmodule // aw_host

//--- tb_alarm_warning_flag_logic.sv
`timescale 1ns/1ps
module tb_alarm_warning_flag_logic;
    logic core_clk = 0;
    logic arst_n = 0;
    aw_pkg::aw_meas_s meas = '0;
    aw_pkg::aw_limit_s [3:0] al = {4{32'h0100_0080}};
    aw_pkg::aw_limit_s [3:0] wl = {4{32'h00c0_0090}};
    aw_pkg::aw_limit_s rxl = 32'h0100_0080;
    aw_pkg::aw_req_s req;
    logic [7:0] rsp_data, st_a, st_r, st_w, ea, er, ew, d;
    logic rsp_valid, ok;
    int n_fail = 0;
    int comparisons = 0;
    // Negative last value splits signed heat from unsigned channels
    logic [15:0] vals [6] = '{16'h0101, 16'h0100, 16'h00c1, 16'h0090, 16'h007f, 16'hff00};
    always #5 core_clk = ~core_clk;
    aw_flag_logic dut (.core_clk(core_clk), .arst_n(arst_n), .meas(meas), .alarm_limit(al),
        .warn_limit(wl), .rx_alarm_limit(rxl), .req(req), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .alarm_status_primary(st_a), .alarm_status_rx_power(st_r),
        .warning_status_primary(st_w));
    aw_host host (.core_clk(core_clk), .req(req), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
    task complete_run;
        $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task rdc(input logic [7:0] a, e);
        host.rd(8'ha2, a, d, ok);
        chk("rsp_valid", 8'h01, {7'h00, ok});
        chk("rsp_data", e, d);
    endtask
    task conv(input logic [2:0] c, input logic [15:0] v);
        meas <= '{1'b1, aw_pkg::aw_chan_e'(c), v};
        @(posedge core_clk);
        meas.valid <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic [1:0] cmp(input logic [2:0] c, input logic [15:0] v,
        input aw_pkg::aw_limit_s l);
        if (c == 3'h0) return {$signed(v) > $signed(l.upper), $signed(v) < $signed(l.lower)};
        return {v > l.upper, v < l.lower};
    endfunction
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        ea = 8'h00;
        er = 8'h00;
        ew = 8'h00;
        rdc(8'h70, 8'h00);
        rdc(8'h71, 8'h00);
        rdc(8'h74, 8'h00);
        for (int c = 0; c < 5; c++) begin
            foreach (vals[k]) begin
                conv(c[2:0], vals[k]);
                if (c < 4) begin
                    ea[7-2*c -: 2] = cmp(c[2:0], vals[k], al[c]);
                    ew[7-2*c -: 2] = cmp(c[2:0], vals[k], wl[c]);
                end else er[7:6] = cmp(c[2:0], vals[k], rxl);
                rdc(8'h70, ea);
                rdc(8'h71, er);
                rdc(8'h74, ew);
                chk("alarm_status_primary", ea, st_a);
                chk("alarm_status_rx_power", er, st_r);
                chk("warning_status_primary", ew, st_w);
            end
        end
        conv(3'h5, 16'h0000);
        host.wr(8'h70, 8'h00);
        host.wr(8'h74, 8'h00);
        rdc(8'h70, ea);
        rdc(8'h74, ew);
        rdc(8'h72, 8'h00);
        host.rd(8'ha0, 8'h70, d, ok);
        chk("foreign_dev", 8'h00, {7'h00, ok});
        arst_n <= 1'b0;
        @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rdc(8'h70, 8'h00);
        complete_run;
    end
    initial begin
        #50us;
        n_fail++;
        complete_run;
    end
endmodule // tb_alarm_warning_flag_logic
